// ---- src/sbtc_pkg.sv ----
/*
 Constants for the two-wire bus timing and configuration block: register
 offset, field positions, reset value and bit-timing counts.
 Assumes a single system clock; timer overflows arrive as one-cycle pulses.
*/
package sbtc_pkg;
   localparam int ADDR_W = 8;
   localparam int CFG_W = 8;
   localparam int BYTE_W = 8;
   localparam logic [ADDR_W-1:0] CFG_ADDR = 8'hC1;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam int BIT_EN = 7;
   localparam int BIT_INH = 6;
   localparam int BIT_BUSY = 5;
   localparam int BIT_SDA_HOLD_EXTEND = 4;
   localparam int BIT_TOE = 3;
   localparam int BIT_FTE = 2;
   localparam int BIT_CS_HI = 1;
   localparam int BIT_CS_LO = 0;
   // Busy is hardware owned; software writes to it are dropped
   localparam logic [CFG_W-1:0] CFG_WR_MASK = 8'hDF;
   localparam logic [1:0] CS_T0 = 2'h0;
   localparam logic [1:0] CS_T1 = 2'h1;
   localparam logic [1:0] CS_T2H = 2'h2;
   localparam logic [1:0] CS_T2L = 2'h3;
   // Phase lengths in clock-source overflow periods
   localparam logic [1:0] LOW_TICKS = 2'h1;
   localparam logic [1:0] HIGH_TICKS = 2'h2;
   localparam logic [1:0] START_TICKS = 2'h1;
   localparam logic [1:0] STOP_TICKS = 2'h1;
   localparam logic [3:0] FREE_TICKS = 4'hA;
   // SDA hold and setup in system clocks
   localparam logic [3:0] HOLD_STD = 4'h3;
   localparam logic [3:0] HOLD_EXT = 4'hC;
   localparam logic [3:0] SETUP_STD = 4'h1;
   localparam logic [3:0] SETUP_EXT = 4'hB;
   localparam logic [3:0] ACK_BIT = 4'h8;
endpackage

// ---- src/sbtc_stream_if.sv ----
/*
 Valid/ready byte stream between the block's own modules.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface sbtc_stream_if #(parameter int W = 8) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- src/sbtc_sync.sv ----
/*
 Two-flop synchroniser for a group of asynchronous levels.
 Assumes the levels change slowly against the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_sync #(parameter int W = 2) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   // Idle bus level is high, so reset to ones
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         meta_q <= '1;
         sync_o <= '1;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- src/sbtc_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_fifo #(parameter int W = 8, parameter int DEPTH = 8) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   sbtc_stream_if.snk in_s,
   sbtc_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_s.ready = (cnt_q != FULL_CNT);
   assign out_s.valid = (cnt_q != '0);
   assign out_s.data = mem[rp_q];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wp_q] <= in_s.data;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/sbtc_top.sv ----
/*
 Two-wire bus timing block: configuration register, master SCL/SDA
 generation from a selected timer overflow, setup/hold control, START/STOP
 and busy tracking, bus-free timeout and SCL-low timer gating.
 Assumes timer overflows and slave events are pulses on core_clk_i, and the
 pins are open drain with pull-ups outside.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_top #(parameter int FIFO_DEPTH = 8) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [sbtc_pkg::ADDR_W-1:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [sbtc_pkg::CFG_W-1:0] sfr_wdata_i,
   output logic [sbtc_pkg::CFG_W-1:0] sfr_rdata_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic t0_ovf_i,
   input wire logic t1_ovf_i,
   input wire logic t2h_ovf_i,
   input wire logic t2l_ovf_i,
   input wire logic t3_split_i,
   output logic t3_reload_hi_o,
   output logic t3_reload_lo_o,
   output logic t3_count_en_o,
   input wire logic [sbtc_pkg::BYTE_W-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic slave_event_i,
   output logic irq_o
);
   import sbtc_pkg::*;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_START = 5'h02,
      ST_LOW = 5'h04,
      ST_HIGH = 5'h08,
      ST_STOP = 5'h10
   } sbtc_state_t;

   sbtc_state_t state_q;
   logic [CFG_W-1:0] cfg_q;
   logic busy_q;
   logic inh_eff_q;
   logic [1:0] lines_s;
   logic scl_s;
   logic sda_s;
   logic scl_p_q;
   logic sda_p_q;
   logic tick;
   logic start_det;
   logic stop_det;
   logic free_det;
   logic [3:0] free_cnt_q;
   logic scl_drv_q;
   logic sda_drv_q;
   logic [BYTE_W-1:0] shreg_q;
   logic [3:0] bit_cnt_q;
   logic [1:0] ph_ticks_q;
   logic [1:0] ph_inc;
   logic [3:0] hold_cnt_q;
   logic [3:0] setup_cnt_q;
   logic upd_q;
   logic stop_q;
   logic hi_seen_q;
   logic [3:0] hold_lim;
   logic [3:0] setup_lim;
   logic sda_next;
   logic start_go;
   logic high_end;
   logic low_end;
   logic pop;
   logic cfg_en;
   logic cfg_inh;
   logic cfg_ext;
   logic cfg_toe;
   logic cfg_fte;
   logic [1:0] cfg_cs;

   sbtc_stream_if #(.W(BYTE_W)) tx_if ();
   sbtc_stream_if #(.W(BYTE_W)) eng_if ();

   assign tx_if.valid = tx_valid_i;
   assign tx_if.data = tx_data_i;
   assign tx_ready_o = tx_if.ready;
   assign eng_if.ready = pop;

   sbtc_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_s(tx_if),
      .out_s(eng_if)
   );

   sbtc_sync #(.W(2)) u_sync (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({scl_i, sda_i}),
      .sync_o(lines_s)
   );

   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];

   assign cfg_en = cfg_q[BIT_EN];
   assign cfg_inh = cfg_q[BIT_INH];
   assign cfg_ext = cfg_q[BIT_SDA_HOLD_EXTEND];
   assign cfg_toe = cfg_q[BIT_TOE];
   assign cfg_fte = cfg_q[BIT_FTE];
   assign cfg_cs = cfg_q[BIT_CS_HI:BIT_CS_LO];

   // Open drain: the pin is only ever pulled low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_drv_q;
   assign sda_oe_o = sda_drv_q;

   always_comb begin
      case (cfg_cs)
         CS_T0: tick = t0_ovf_i;
         CS_T1: tick = t1_ovf_i;
         CS_T2H: tick = t2h_ovf_i;
         CS_T2L: tick = t2l_ovf_i;
         default: tick = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cfg_q <= CFG_RESET;
      end else if (sfr_wr_i && sfr_addr_i == CFG_ADDR) begin
         cfg_q <= sfr_wdata_i & CFG_WR_MASK;
      end
   end

   // Read data holds until the next read; unmapped reads return zero
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sfr_rdata_o <= '0;
      end else if (sfr_rd_i) begin
         if (sfr_addr_i == CFG_ADDR) begin
            sfr_rdata_o <= (cfg_q & CFG_WR_MASK) | (CFG_W'(busy_q) << BIT_BUSY);
         end else begin
            sfr_rdata_o <= '0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign start_det = cfg_en && scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_det = cfg_en && scl_s && scl_p_q && !sda_p_q && sda_s;

   assign free_det = cfg_en && cfg_fte && scl_s && sda_s && tick && (free_cnt_q == FREE_TICKS);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         free_cnt_q <= '0;
      end else if (!cfg_en || !cfg_fte || !scl_s || !sda_s) begin
         free_cnt_q <= '0;
      end else if (tick && free_cnt_q <= FREE_TICKS) begin
         free_cnt_q <= free_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         busy_q <= 1'b0;
      end else if (!cfg_en) begin
         busy_q <= 1'b0;
      end else if (start_det) begin
         busy_q <= 1'b1;
      end else if (stop_det || free_det) begin
         busy_q <= 1'b0;
      end
   end

   // inhibit takes hold at once while the bus is not busy, otherwise at the next START or once busy clears
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         inh_eff_q <= 1'b0;
      end else if (start_det || !busy_q) begin
         inh_eff_q <= cfg_inh;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= cfg_en && (start_go || (slave_event_i && !inh_eff_q));
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         t3_reload_hi_o <= 1'b0;
         t3_reload_lo_o <= 1'b0;
         t3_count_en_o <= 1'b0;
      end else begin
         t3_reload_hi_o <= cfg_en && cfg_toe && scl_s;
         t3_reload_lo_o <= cfg_en && cfg_toe && scl_s && !t3_split_i;
         t3_count_en_o <= cfg_en && cfg_toe && !scl_s;
      end
   end

   assign hold_lim = cfg_ext ? HOLD_EXT : HOLD_STD;
   assign setup_lim = cfg_ext ? SETUP_EXT : SETUP_STD;

   assign sda_next = stop_q ? 1'b1 : ((bit_cnt_q == ACK_BIT) ? 1'b0 : !shreg_q[BYTE_W-1]);
   assign ph_inc = (ph_ticks_q == 2'h3) ? ph_ticks_q : ph_ticks_q + 2'h1;

   // Master only starts on an idle bus seen through the synchroniser
   assign start_go = cfg_en && (state_q == ST_IDLE) && eng_if.valid && !busy_q && scl_s && sda_s;

   // high phase ends early if SCL pulled low
   assign high_end = (state_q == ST_HIGH) && (ph_ticks_q >= HIGH_TICKS || (hi_seen_q && !scl_s));

   assign low_end = (state_q == ST_LOW) && upd_q && setup_cnt_q >= setup_lim &&
                    ph_ticks_q >= LOW_TICKS;

   assign pop = start_go || (cfg_en && high_end && bit_cnt_q == ACK_BIT && eng_if.valid);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || !cfg_en) begin
         state_q <= ST_IDLE;
         scl_drv_q <= 1'b0;
         sda_drv_q <= 1'b0;
         shreg_q <= '0;
         bit_cnt_q <= '0;
         ph_ticks_q <= '0;
         hold_cnt_q <= '0;
         setup_cnt_q <= '0;
         upd_q <= 1'b0;
         stop_q <= 1'b0;
         hi_seen_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_go) begin
                  state_q <= ST_START;
                  sda_drv_q <= 1'b1;
                  shreg_q <= eng_if.data;
                  bit_cnt_q <= '0;
                  ph_ticks_q <= '0;
                  stop_q <= 1'b0;
               end
            end
            ST_START: begin
               if (tick && scl_s) begin
                  ph_ticks_q <= ph_inc;
               end
               if (ph_ticks_q >= START_TICKS) begin
                  state_q <= ST_LOW;
                  scl_drv_q <= 1'b1;
                  ph_ticks_q <= '0;
                  hold_cnt_q <= '0;
                  upd_q <= 1'b0;
               end
            end
            ST_LOW: begin
               if (tick) begin
                  ph_ticks_q <= ph_inc;
               end
               if (!scl_s && !upd_q && hold_cnt_q < hold_lim) begin
                  hold_cnt_q <= hold_cnt_q + 4'h1;
               end
               if (!upd_q && hold_cnt_q >= hold_lim) begin
                  upd_q <= 1'b1;
                  setup_cnt_q <= '0;
                  sda_drv_q <= sda_next;
               end
               if (upd_q && setup_cnt_q < setup_lim) begin
                  setup_cnt_q <= setup_cnt_q + 4'h1;
               end
               if (low_end) begin
                  scl_drv_q <= 1'b0;
                  ph_ticks_q <= '0;
                  hi_seen_q <= 1'b0;
                  state_q <= stop_q ? ST_STOP : ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (scl_s) begin
                  hi_seen_q <= 1'b1;
               end
               if (tick && scl_s) begin
                  ph_ticks_q <= ph_inc;
               end
               if (high_end) begin
                  scl_drv_q <= 1'b1;
                  ph_ticks_q <= '0;
                  hold_cnt_q <= '0;
                  upd_q <= 1'b0;
                  state_q <= ST_LOW;
                  if (bit_cnt_q == ACK_BIT) begin
                     // Acknowledge value is not judged here; an empty FIFO ends the frame
                     if (eng_if.valid) begin
                        shreg_q <= eng_if.data;
                        bit_cnt_q <= '0;
                     end else begin
                        stop_q <= 1'b1;
                     end
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     shreg_q <= {shreg_q[BYTE_W-2:0], 1'b0};
                  end
               end
            end
            ST_STOP: begin
               if (tick && scl_s) begin
                  ph_ticks_q <= ph_inc;
               end
               if (ph_ticks_q >= STOP_TICKS) begin
                  sda_drv_q <= 1'b0;
                  stop_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               scl_drv_q <= 1'b0;
               sda_drv_q <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- tb/sbtc_asserts.sv ----
/*
 Port checker for sbtc_top: timer gating, register reads, SCL phases, SDA hold.
 Assumes it is bound to sbtc_top and the synchroniser resets to bus idle.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_asserts (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [sbtc_pkg::ADDR_W-1:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [sbtc_pkg::CFG_W-1:0] sfr_wdata_i,
   input wire logic [sbtc_pkg::CFG_W-1:0] sfr_rdata_o,
   input wire logic scl_i,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o,
   input wire logic t3_split_i,
   input wire logic t3_reload_hi_o,
   input wire logic t3_reload_lo_o,
   input wire logic t3_count_en_o,
   input wire logic irq_o
);
   import sbtc_pkg::*;
   logic [CFG_W-1:0] cfg_q;
   logic [1:0] scl_q;
   wire logic tmr_on = cfg_q[BIT_EN] & cfg_q[BIT_TOE];
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cfg_q <= CFG_RESET;
      end else if (sfr_wr_i && sfr_addr_i == CFG_ADDR) begin
         cfg_q <= sfr_wdata_i & CFG_WR_MASK;
      end
   end
   // Mirrors the design's two-flop view of SCL, idle high in reset
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         scl_q <= 2'h3;
      end else begin
         scl_q <= {scl_q[0], scl_i};
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence rel_s;
      $fell(scl_oe_o) && cfg_q[BIT_EN];
   endsequence
   sequence grab_s;
      $rose(scl_oe_o) && cfg_q[BIT_EN];
   endsequence
   sequence fall_s;
      $fell(scl_q[1]) && cfg_q[BIT_EN];
   endsequence
   reload_hi_a: assert property (
      t3_reload_hi_o == $past(tmr_on & scl_q[1])) else $error("reload high wrong");
   reload_lo_a: assert property (
      t3_reload_lo_o == $past(tmr_on & scl_q[1] & !t3_split_i)) else $error("reload low wrong");
   count_en_a: assert property (
      t3_count_en_o == $past(tmr_on & !scl_q[1])) else $error("count enable wrong");
   rd_cfg_a: assert property (
      sfr_rd_i && sfr_addr_i == CFG_ADDR |=> (sfr_rdata_o & CFG_WR_MASK) == $past(cfg_q))
      else $error("config readback wrong");
   rd_none_a: assert property (
      sfr_rd_i && sfr_addr_i != CFG_ADDR |=> sfr_rdata_o == 8'h00) else $error("unmapped read");
   off_idle_a: assert property (
      !cfg_q[BIT_EN] |=> !scl_oe_o && !sda_oe_o && !irq_o) else $error("active while off");
   start_irq_a: assert property (
      $rose(sda_oe_o) && !scl_oe_o |-> irq_o) else $error("no irq on start");
   scl_high_a: assert property (
      rel_s |-> !scl_oe_o [*3]) else $error("scl high too short");
   scl_low_a: assert property (
      grab_s |-> scl_oe_o [*4]) else $error("scl low too short");
   hold_std_a: assert property (
      fall_s |-> $stable(sda_oe_o) [*3]) else $error("sda hold short");
   hold_ext_a: assert property (
      fall_s and cfg_q[BIT_SDA_HOLD_EXTEND] |-> $stable(sda_oe_o) [*8]) else $error("sda ext hold short");
endmodule
`default_nettype wire

// ---- tb/sbtc_bus_model.sv ----
/*
 Far side of the bus: pull-ups, a stretching slave and byte capture.
 Assumes open-drain enables from every party and the core clock for sampling.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_bus_model (
   input wire logic core_clk_i,
   input wire logic scl_oe_i,
   input wire logic sda_oe_i,
   input wire logic hold_scl_i,
   input wire logic xscl_low_i,
   input wire logic xsda_low_i,
   output logic scl_o,
   output logic sda_o,
   output logic [63:0] rx_all_o,
   output logic [3:0] nbyte_o,
   output logic [7:0] hmin_o
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic [3:0] nbit = 4'h0;
   logic [7:0] sh = 8'h00;
   int hlen = 0;
   initial begin
      rx_all_o = 64'h0;
      nbyte_o = 4'h0;
      hmin_o = 8'hFF;
   end
   // Slave holds SCL low; lines are wired-AND with pull-ups
   assign scl_o = !(scl_oe_i || hold_scl_i || xscl_low_i);
   assign sda_o = !(sda_oe_i || xsda_low_i);
   always @(posedge core_clk_i) begin
      scl_q <= scl_o;
      sda_q <= sda_o;
      hlen <= scl_o ? hlen + 1 : 0;
      if (scl_q && !scl_o && hlen < hmin_o) begin
         hmin_o <= hlen[7:0];
      end
      if (scl_o && scl_q && sda_q && !sda_o) begin
         nbit <= 4'h0;
      end else if (scl_o && !scl_q) begin
         if (nbit == 4'h8) begin
            rx_all_o <= {rx_all_o[55:0], sh};
            nbyte_o <= nbyte_o + 4'h1;
            nbit <= 4'h0;
         end else begin
            sh <= {sh[6:0], sda_o};
            nbit <= nbit + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/sbtc_bench.sv ----
/*
 Self-checking bench for sbtc_top: register, inhibit, master frame, free timeout.
 Assumes a 100 MHz core clock; timer overflows are made here.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_bench;
   import sbtc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] rdata, hmin;
   logic [63:0] rx_all;
   logic [3:0] ovf_man = 4'h0;
   logic [3:0] ovf_run = 4'h0;
   // Hand-made pulses and the free-running ticker are ORed onto all four overflows
   wire logic [3:0] ovf = ovf_man | ovf_run;
   logic [3:0] nbyte;
   logic [1:0] tick_sel = 2'h0;
   logic wr = 1'b0, rd = 1'b0, split = 1'b0, tx_valid = 1'b0, sev = 1'b0;
   logic hold = 1'b0, xscl = 1'b0, xsda = 1'b0, tick_run = 1'b0;
   logic scl, sda, scl_oe, sda_oe, tx_ready, irq, rl_hi, rl_lo, cnt_en;
   int mismatches = 0;
   int tests_run = 0;
   int tcnt = 0;
   sbtc_top #(.FIFO_DEPTH(8)) u_dut (
      .core_clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .scl_i(scl),
      .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe),
      .t0_ovf_i(ovf[0]), .t1_ovf_i(ovf[1]), .t2h_ovf_i(ovf[2]), .t2l_ovf_i(ovf[3]),
      .t3_split_i(split), .t3_reload_hi_o(rl_hi), .t3_reload_lo_o(rl_lo),
      .t3_count_en_o(cnt_en), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .slave_event_i(sev), .irq_o(irq));
   sbtc_bus_model u_bus (
      .core_clk_i(clk), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .hold_scl_i(hold),
      .xscl_low_i(xscl), .xsda_low_i(xsda), .scl_o(scl), .sda_o(sda),
      .rx_all_o(rx_all), .nbyte_o(nbyte), .hmin_o(hmin));
   initial begin
      forever #5 clk = ~clk;
   end
   // Free-running overflow, one pulse every four clocks
   always @(negedge clk) begin
      if (tick_run) begin
         tcnt <= (tcnt + 1) % 4;
         ovf_run <= (tcnt == 0) ? 4'h1 << tick_sel : 4'h0;
      end else begin
         ovf_run <= 4'h0;
      end
   end
   task automatic print_verdict();
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bail(input bit hit);
      if (hit) begin
         mismatches++;
         print_verdict();
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = rdata;
   endtask
   task automatic ticks(input int n, input logic [1:0] s);
      repeat (n) begin
         @(negedge clk);
         ovf_man = 4'h1 << s;
         @(negedge clk);
         ovf_man = 4'h0;
         repeat (2) @(negedge clk);
      end
   endtask
   // Other master on an 80 ns link clock: START, SDA up while SCL low, then three clocks
   task automatic ext_start();
      xsda = 1'b1;
      #40 xscl = 1'b1;
      #40 xsda = 1'b0;
      repeat (3) begin
         #40 xscl = 1'b0;
         #40 xscl = 1'b1;
      end
      #40 check_eq(cnt_en, 1'b1);
      xscl = 1'b0;
      #60 check_eq(rl_hi, 1'b1);
      check_eq(rl_lo, !split);
   endtask
   task automatic test_regs();
      logic [7:0] d;
      rd_reg(CFG_ADDR, d);
      check_eq(d, CFG_RESET);
      wr_reg(CFG_ADDR, 8'hFF);
      rd_reg(CFG_ADDR, d);
      check_eq(d, CFG_WR_MASK);
      wr_reg(CFG_ADDR, 8'h00);
      wr_reg(8'hC0, 8'hFF);
      rd_reg(CFG_ADDR, d);
      check_eq(d, 8'h00);
      rd_reg(8'hC0, d);
      check_eq(d, 8'h00);
   endtask
   task automatic test_inhibit();
      int n;
      for (int i = 0; i < 2; i++) begin
         wr_reg(CFG_ADDR, (i == 1) ? 8'hC0 : 8'h80);
         n = 0;
         @(negedge clk);
         sev = 1'b1;
         @(negedge clk);
         sev = 1'b0;
         repeat (4) begin
            n = n + (irq === 1'b1);
            @(negedge clk);
         end
         check_eq(n[7:0], (i == 1) ? 8'h00 : 8'h01);
      end
   endtask
   task automatic test_master(input logic [7:0] cfg);
      logic [7:0] d;
      logic [3:0] n0;
      int k;
      wr_reg(CFG_ADDR, 8'h00);
      n0 = nbyte;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         check_eq(tx_ready, 1'b1);
         tx_data = {i[3:0], ~i[3:0]};
         tx_valid = 1'b1;
      end
      @(negedge clk);
      tx_valid = 1'b0;
      check_eq(tx_ready, 1'b0);
      tick_sel = CS_T1;
      tick_run = 1'b1;
      wr_reg(CFG_ADDR, cfg);
      k = 0;
      // Byte count is relative, so a second frame needs no reset of the model
      while (nbyte != n0 + 4'h8 && k < 20000) begin
         @(negedge clk);
         k++;
         hold = nbyte == n0 + 4'h2 && k % 64 < 40 && (hold || !scl);
      end
      hold = 1'b0;
      bail(k >= 20000);
      k = 0;
      do begin
         rd_reg(CFG_ADDR, d);
         k++;
      end while (d[5] !== 1'b0 && k < 200);
      bail(k >= 200);
      check_eq(tx_ready, 1'b1);
      for (int i = 0; i < 8; i++) begin
         check_eq(rx_all[8*(7-i) +: 8], {i[3:0], ~i[3:0]});
      end
      check_eq(hmin >= 8'd7, 1'b1);
      @(negedge clk);
      tick_run = 1'b0;
   endtask
   task automatic test_free();
      logic [7:0] d;
      for (int c = 0; c < 4; c++) begin
         wr_reg(CFG_ADDR, 8'h8C | c[7:0]);
         split = c[0];
         ext_start();
         rd_reg(CFG_ADDR, d);
         check_eq(d[5], 1'b1);
         ticks(12, c[1:0] + 2'h1);
         ticks(10, c[1:0]);
         rd_reg(CFG_ADDR, d);
         check_eq(d[5], 1'b1);
         ticks(1, c[1:0]);
         rd_reg(CFG_ADDR, d);
         check_eq(d[5], 1'b0);
      end
      // Low-timeout handler recovers a stuck bus by disabling and re-enabling
      ext_start();
      xscl = 1'b1;
      wr_reg(CFG_ADDR, 8'h00);
      wr_reg(CFG_ADDR, 8'h8C);
      rd_reg(CFG_ADDR, d);
      check_eq(d, 8'h8C);
      check_eq(cnt_en, 1'b1);
      xscl = 1'b0;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      test_regs();
      test_inhibit();
      // Core clock is above 10 MHz, so the hold extension is on for the first frame; the second runs with it off
      test_master(8'h91);
      test_master(8'h81);
      test_free();
      print_verdict();
   end
endmodule
bind sbtc_top sbtc_asserts u_chk (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o), .scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
   .t3_split_i(t3_split_i), .t3_reload_hi_o(t3_reload_hi_o),
   .t3_reload_lo_o(t3_reload_lo_o), .t3_count_en_o(t3_count_en_o), .irq_o(irq_o));
`default_nettype wire
